// >>> hdl/prox_ctrl_defines.vh
// constants for the proximity sensor control register bank
// assumes a single 200 MHz clock; the i2c pins are already synchronous
//
// Contract
// R01: identification byte fixed, writes ignored
// R02: restart bit plus stop restores standby
// R03: restart acts as power-on reset; the i2c register pointer ptr keeps its value here
// R04: level mode holds pin while status set
// R05: pulse mode pulses per measurement while set
// R06: latched mode holds until status read
// R07: follow mode re-evaluates after each measurement
// R08: bit zero selects pin polarity
// R09: led rate is 4 MHz over divider
// R10: host programs divider 2 to 31 only
// R11: divider resets to 16
// R12: wait programmed lag after led edge
// R13: lag 0/1 none, else (N-1)*125 ns
// R14: lag resets to five
// R15: host keeps lag within divider
// R16: out-of-window measurement sets interrupt status
// R17: block write acks, pointer advances
// R18: upper bits ignored, read as zero
`ifndef PROX_CTRL_DEFINES_VH
`define PROX_CTRL_DEFINES_VH

// ----------------------------------------
// bus addressing
// ----------------------------------------
`define SLAVE_ADDR 7'h37
`define REG_IDENT 8'h00
`define REG_RESTART 8'h01
`define REG_IRQ_SETUP 8'h02
`define REG_RATE 8'h0D
`define REG_LAG 8'h0E
`define REG_IRQ_STATUS 8'h40

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RESTART_BIT 0
`define IRQ_POL_BIT 0
`define IRQ_FOLLOW_BIT 1
`define IRQ_PULSE_BIT 2
`define IRQ_SETUP_RST 3'h2
`define RATE_RST 5'h10
`define LAG_RST 5'h05
`define RATE_MIN 5'h02

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_KHZ 200000
`define LED_BASE_KHZ 4000
`define LED_TICK_CYCLES (`CLK_KHZ / `LED_BASE_KHZ)
`define DELAY_STEP_NS 125
`define DELAY_STEP_CYCLES ((`DELAY_STEP_NS * `CLK_KHZ + 999999) / 1000000)
`define IRQ_PULSE_NS 1000
`define IRQ_PULSE_CYCLES ((`IRQ_PULSE_NS * `CLK_KHZ + 999999) / 1000000)

`endif

// >>> hdl/emitter_timing.v
// led pulse generator and sample strobe after each led edge
// assumes divider and lag come straight from the register bank
`timescale 1ns/1ps
`default_nettype none
`include "prox_ctrl_defines.vh"

module emitter_timing #(
    parameter integer TICK_CYCLES = `LED_TICK_CYCLES,
    parameter integer STEP_CYCLES = `DELAY_STEP_CYCLES
) (
    // clock and reset
    input wire ref_clk,
    input wire resetn,
    input wire restart,
    // settings
    input wire [4:0] divider,
    input wire [4:0] lag,
    // timing outputs
    output reg led_drive,
    output reg sample_strobe
);

localparam [7:0] TICK_LAST = TICK_CYCLES[7:0] - 8'h01;
localparam [9:0] STEP = STEP_CYCLES[9:0];

reg [7:0] tick_cnt;
reg [4:0] phase;
reg [9:0] dly;
reg pending;
reg [4:0] next_phase;
reg [4:0] n_eff;
reg [4:0] half;
wire tick;
wire edge_now;

assign tick = (tick_cnt == TICK_LAST);
// any real change of the led level counts, so the first rising edge
// after reset or restart also gets its sample strobe
assign edge_now = tick && ((next_phase < half) != led_drive);

always @* begin
    // out-of-range divider clamps rather than stalling the led
    n_eff = (divider < `RATE_MIN) ? `RATE_MIN : divider;
    half = n_eff >> 1;
    next_phase = (phase >= n_eff - 5'h01) ? 5'h00 : phase + 5'h01; // R09
end

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        tick_cnt <= 8'h00;
        phase <= 5'h00;
        led_drive <= 1'b0;
        dly <= 10'h000;
        pending <= 1'b0;
        sample_strobe <= 1'b0;
    end else if (restart) begin
        tick_cnt <= 8'h00;
        phase <= 5'h00;
        led_drive <= 1'b0;
        dly <= 10'h000;
        pending <= 1'b0;
        sample_strobe <= 1'b0;
    end else begin
        tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
        sample_strobe <= 1'b0;
        if (tick) begin
            phase <= next_phase;
            led_drive <= (next_phase < half); // R09
        end
        if (edge_now) begin
            pending <= 1'b1; // R12
            if (lag <= 5'h01) begin
                dly <= 10'h000; // R13
            end else begin
                dly <= {5'h00, lag - 5'h01} * STEP; // R13
            end
        end else if (pending) begin
            if (dly == 10'h000) begin
                sample_strobe <= 1'b1; // R12
                pending <= 1'b0;
            end else begin
                dly <= dly - 10'h001;
            end
        end
    end
end

endmodule
`default_nettype wire

// >>> hdl/prox_sensor_ctrl_regs.v
// control register bank of the proximity sensor behind an i2c slave
// assumes scl and sda are already synchronous to ref_clk and that the
// measurement core gives one done pulse with its window verdict
`timescale 1ns/1ps
`default_nettype none
`include "prox_ctrl_defines.vh"

module prox_sensor_ctrl_regs #(
    // arbitrary values, not a real part code or revision
    parameter [3:0] PART_CODE = 4'hA,
    parameter [3:0] REVISION = 4'h1,
    parameter integer PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
    // clock and reset
    input wire ref_clk,
    input wire resetn,
    // i2c pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_n,
    // measurement core
    input wire meas_done,
    input wire out_of_window,
    // to the rest of the unit
    output reg irq_pin,
    output reg irq_status,
    output reg unit_restart,
    output wire led_drive,
    output wire sample_strobe
);

// ----------------------------------------
// states
// ----------------------------------------
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_DEV = 4'h1;
localparam [3:0] ST_DEV_ACK = 4'h2;
localparam [3:0] ST_PTR = 4'h3;
localparam [3:0] ST_PTR_ACK = 4'h4;
localparam [3:0] ST_WR = 4'h5;
localparam [3:0] ST_WR_ACK = 4'h6;
localparam [3:0] ST_RD = 4'h7;
localparam [3:0] ST_RD_ACK = 4'h8;
localparam [7:0] PULSE_LAST = PULSE_CYCLES[7:0];

reg scl_q;
reg sda_q;
reg [3:0] state;
reg [3:0] bit_cnt;
reg [7:0] rx;
reg [7:0] tx;
reg [7:0] ptr;
reg rw;
reg wr_stb;
reg [7:0] wr_addr;
reg [7:0] wr_data;
reg status_read;
reg restart_armed;
reg [2:0] irq_setup;
reg [4:0] rate_div;
reg [4:0] lag;
reg [7:0] pulse_cnt;
reg meas_seen;
reg [7:0] rd_data;
reg active;

wire scl_rise = scl_in & ~scl_q;
wire scl_fall = ~scl_in & scl_q;
wire start_seen = scl_in & scl_q & sda_q & ~sda_in;
wire stop_seen = scl_in & scl_q & ~sda_q & sda_in;
wire soft_reset = stop_seen & restart_armed;

// open drain: only ever pulls low
assign sda_out = 1'b0;

// ----------------------------------------
// read mux
// ----------------------------------------
always @* begin
    case (ptr)
        `REG_IDENT: rd_data = {PART_CODE, REVISION}; // R01
        `REG_RESTART: rd_data = {7'h00, restart_armed}; // R18
        `REG_IRQ_SETUP: rd_data = {5'h00, irq_setup}; // R18
        `REG_RATE: rd_data = {3'h0, rate_div}; // R18
        `REG_LAG: rd_data = {3'h0, lag}; // R18
        `REG_IRQ_STATUS: rd_data = {7'h00, irq_status};
        default: rd_data = 8'h00;
    endcase
end

// ----------------------------------------
// i2c slave
// ----------------------------------------
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        scl_q <= 1'b1;
        sda_q <= 1'b1;
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        rx <= 8'h00;
        tx <= 8'h00;
        ptr <= 8'h00;
        rw <= 1'b0;
        sda_oe_n <= 1'b1;
        wr_stb <= 1'b0;
        wr_addr <= 8'h00;
        wr_data <= 8'h00;
        status_read <= 1'b0;
    end else begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        wr_stb <= 1'b0;
        status_read <= 1'b0;
        if (start_seen) begin
            state <= ST_DEV;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b1;
        end else if (stop_seen) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    sda_oe_n <= 1'b1;
                end
                ST_DEV, ST_PTR, ST_WR: begin
                    if (scl_rise) begin
                        rx <= {rx[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        sda_oe_n <= 1'b0;
                        if (state == ST_DEV) begin
                            rw <= rx[0];
                            if (rx[7:1] == `SLAVE_ADDR) begin
                                state <= ST_DEV_ACK;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state <= ST_IDLE;
                            end
                        end else if (state == ST_PTR) begin
                            ptr <= rx;
                            state <= ST_PTR_ACK;
                        end else begin
                            wr_stb <= 1'b1; // R17
                            wr_addr <= ptr;
                            wr_data <= rx;
                            ptr <= ptr + 8'h01; // R17
                            state <= ST_WR_ACK;
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            tx <= rd_data;
                            sda_oe_n <= rd_data[7];
                            status_read <= (ptr == `REG_IRQ_STATUS);
                            state <= ST_RD;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state <= ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'b1;
                        state <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            bit_cnt <= 4'h0;
                            sda_oe_n <= 1'b1;
                            ptr <= ptr + 8'h01;
                            state <= ST_RD_ACK;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe_n <= tx[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        rx <= {rx[6:0], sda_in};
                    end else if (scl_fall) begin
                        if (rx[0]) begin
                            // master said no more: wait for stop
                            state <= ST_IDLE;
                        end else begin
                            tx <= rd_data;
                            sda_oe_n <= rd_data[7];
                            status_read <= (ptr == `REG_IRQ_STATUS);
                            state <= ST_RD;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end
end

// ----------------------------------------
// register bank
// ----------------------------------------
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        restart_armed <= 1'b0;
        irq_setup <= `IRQ_SETUP_RST;
        rate_div <= `RATE_RST;
        lag <= `LAG_RST;
        unit_restart <= 1'b0;
    end else if (soft_reset) begin
        restart_armed <= 1'b0; // R03
        irq_setup <= `IRQ_SETUP_RST; // R03
        rate_div <= `RATE_RST; // R11
        lag <= `LAG_RST; // R14
        unit_restart <= 1'b1; // R02
    end else begin
        unit_restart <= 1'b0;
        if (wr_stb) begin
            // identification has no write path
            case (wr_addr)
                `REG_RESTART: restart_armed <= wr_data[`RESTART_BIT]; // R02
                `REG_IRQ_SETUP: irq_setup <= wr_data[2:0]; // R18
                `REG_RATE: rate_div <= wr_data[4:0]; // R09
                `REG_LAG: lag <= wr_data[4:0]; // R12
                default: restart_armed <= restart_armed; // R01
            endcase
        end
    end
end

// ----------------------------------------
// interrupt status and pin
// ----------------------------------------
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        irq_status <= 1'b0;
        irq_pin <= 1'b1;
        pulse_cnt <= 8'h00;
        meas_seen <= 1'b0;
        active <= 1'b0;
    end else if (soft_reset) begin
        irq_status <= 1'b0; // R03
        irq_pin <= 1'b1;
        pulse_cnt <= 8'h00;
        meas_seen <= 1'b0;
        active <= 1'b0;
    end else begin
        meas_seen <= meas_done;
        if (meas_done) begin
            if (irq_setup[`IRQ_FOLLOW_BIT]) begin
                irq_status <= out_of_window; // R07
            end else if (out_of_window) begin
                irq_status <= 1'b1; // R16
            end else if (status_read) begin
                irq_status <= 1'b0; // R06
            end
        end else if (status_read && !irq_setup[`IRQ_FOLLOW_BIT]) begin
            irq_status <= 1'b0; // R06
        end
        // pulse starts once the updated status is visible
        if (meas_seen && irq_status) begin
            pulse_cnt <= PULSE_LAST; // R05
        end else if (pulse_cnt != 8'h00) begin
            pulse_cnt <= pulse_cnt - 8'h01;
        end
        if (irq_setup[`IRQ_PULSE_BIT]) begin
            active <= (pulse_cnt != 8'h00); // R05
        end else begin
            active <= irq_status; // R04
        end
        irq_pin <= irq_setup[`IRQ_POL_BIT] ? active : ~active; // R08
    end
end

// ----------------------------------------
// led timing
// ----------------------------------------
emitter_timing #(
    .TICK_CYCLES(`LED_TICK_CYCLES),
    .STEP_CYCLES(`DELAY_STEP_CYCLES)
) u_timing (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .restart(unit_restart),
    .divider(rate_div),
    .lag(lag),
    .led_drive(led_drive),
    .sample_strobe(sample_strobe)
);

endmodule
`default_nettype wire

// >>> bench/prox_sensor_ctrl_regs_properties.sv
// assertions on the pins of the proximity register bank
// assumes it is bound onto every prox_sensor_ctrl_regs instance
`timescale 1ns/1ps
`default_nettype none
module prox_ctrl_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // watched pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe_n,
    input wire logic meas_done,
    input wire logic out_of_window,
    input wire logic irq_pin,
    input wire logic irq_status,
    input wire logic unit_restart,
    input wire logic led_drive,
    input wire logic sample_strobe
);
    localparam int TICK = 50;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------
    // led edge spacing
    // ------------------------------------------
    // void until one edge after a restart, which cuts a period short
    logic last_led;
    logic fresh;
    int gap;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            last_led <= 1'b0;
            fresh <= 1'b1;
            gap <= 0;
        end else begin
            last_led <= led_drive;
            gap <= (led_drive != last_led) ? 1 : gap + 1;
            fresh <= unit_restart | (fresh & (led_drive == last_led));
        end
    end
    sequence s_edge;
        led_drive != last_led;
    endsequence
    sequence s_strobe_wait;
        ##[1:752] sample_strobe;
    endsequence
    property p_reset_idle;
        $rose(resetn) |-> sda_oe_n && irq_pin && !irq_status;
    endproperty
    property p_restart_pulse;
        unit_restart |=> !unit_restart && !irq_status;
    endproperty
    property p_restart_stop;
        unit_restart |-> $past(scl_in) && $past(sda_in);
    endproperty
    property p_status_set;
        meas_done && out_of_window |=> irq_status;
    endproperty
    property p_status_cause;
        $rose(irq_status) |-> $past(meas_done && out_of_window);
    endproperty
    property p_ack_scl_low;
        $fell(sda_oe_n) |-> !scl_in;
    endproperty
    property p_sda_hold;
        scl_in && $past(scl_in) |-> $stable(sda_oe_n);
    endproperty
    property p_strobe;
        s_edge |-> s_strobe_wait;
    endproperty
    property p_led_ticks;
        s_edge |-> fresh || unit_restart || (gap % TICK == 0);
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
    a_restart_pulse: assert property (p_restart_pulse)
        else $error("restart pulse wrong");
    a_restart_stop: assert property (p_restart_stop)
        else $error("restart without stop");
    a_status_set: assert property (p_status_set)
        else $error("status not set");
    a_status_cause: assert property (p_status_cause)
        else $error("status set without cause");
    a_ack_scl_low: assert property (p_ack_scl_low)
        else $error("sda pulled while scl high");
    a_sda_hold: assert property (p_sda_hold)
        else $error("sda moved while scl high");
    a_strobe: assert property (p_strobe)
        else $error("no strobe after led edge");
    a_led_ticks: assert property (p_led_ticks)
        else $error("led edge off tick grid");
endmodule
bind prox_sensor_ctrl_regs prox_ctrl_checker u_prox_ctrl_checker (
    .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl_in),
    .sda_in(sda_in), .sda_oe_n(sda_oe_n), .meas_done(meas_done),
    .out_of_window(out_of_window), .irq_pin(irq_pin),
    .irq_status(irq_status), .unit_restart(unit_restart),
    .led_drive(led_drive), .sample_strobe(sample_strobe)
);
`default_nettype wire

// >>> bench/i2c_host.sv
// i2c master model facing the register bank
// assumes sda is the resolved wire with a pull-up
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
    // clock
    input wire logic ref_clk,
    // bus
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // five cycles a half period keeps above the four the bank needs
    task automatic step(input logic c, s);
        scl = c;
        sda_m = s;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic bit1(input logic b, output logic r);
        step(1'b0, b);
        step(1'b1, b);
        r = sda;
        step(1'b0, b);
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit1(v[i], r);
        bit1(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit1(1'b1, r);
            v[i] = r;
        end
        bit1(last, r);
    endtask
endmodule
`default_nettype wire

// >>> bench/tb_prox_sensor_ctrl_regs.sv
// self-checking bench of the proximity register bank
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "prox_ctrl_defines.vh"
module tb_prox_sensor_ctrl_regs;
    logic ref_clk, resetn, meas_done, out_of_window;
    logic scl_in, sda_m, sda_w, sda_out, sda_oe_n;
    logic irq_pin, irq_status, unit_restart, led_drive, sample_strobe;
    logic [7:0] d;
    int fail_count = 0;
    int comparisons = 0;
    int restarts = 0;
    localparam logic [7:0] ADR = {`SLAVE_ADDR, 1'b0};
    localparam logic [7:0] RA [6] = '{8'h00, 8'h01, 8'h02, 8'h0D, 8'h0E, 8'h20};
    localparam logic [7:0] RV [6] = '{8'hA1, 8'h00, 8'h02, 8'h10, 8'h05, 8'h00};
    // open drain with pull-up: a released line reads high
    assign sda_w = sda_m & (sda_oe_n | sda_out);
    always @(posedge ref_clk) if (unit_restart === 1'b1) restarts++;
    prox_sensor_ctrl_regs #(.PULSE_CYCLES(4)) u_prox_sensor_ctrl_regs (
        .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl_in),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .meas_done(meas_done), .out_of_window(out_of_window),
        .irq_pin(irq_pin), .irq_status(irq_status),
        .unit_restart(unit_restart), .led_drive(led_drive),
        .sample_strobe(sample_strobe)
    );
    i2c_host u_i2c_host (
        .ref_clk(ref_clk), .sda(sda_w), .scl(scl_in), .sda_m(sda_m)
    );
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic put(input logic [7:0] v);
        logic k;
        u_i2c_host.wbyte(v, k);
        chk("ack", 16'h0001, k);
    endtask
    task automatic hdr(input logic [7:0] a);
        u_i2c_host.start();
        put(ADR);
        put(a);
    endtask
    task automatic wr(input logic [7:0] a, v);
        hdr(a);
        put(v);
        u_i2c_host.stop();
    endtask
    task automatic rd(input logic [7:0] a);
        hdr(a);
        u_i2c_host.start();
        put(ADR | 8'h01);
        u_i2c_host.rbyte(1'b1, d);
        u_i2c_host.stop();
    endtask
    task automatic meas(input logic o);
        meas_done = 1'b1;
        out_of_window = o;
        tick(1);
        meas_done = 1'b0;
        tick(1);
    endtask
    task automatic wpin(input logic v, input int lim);
        for (int n = 0; irq_pin !== v && n < lim; n++) tick(1);
        chk("irq_pin", v, irq_pin);
    endtask
    // high half length and first strobe offset after a rising edge
    task automatic led(output int hi, st);
        for (int n = 0; led_drive !== 1'b0 && n < 2000; n++) tick(1);
        for (int n = 0; led_drive !== 1'b1 && n < 2000; n++) tick(1);
        st = 0;
        for (hi = 0; led_drive === 1'b1 && hi < 2000; hi++) begin
            if (sample_strobe === 1'b1 && st == 0) st = hi;
            tick(1);
        end
    endtask
    task automatic t_defaults();
        for (int i = 0; i < 6; i++) begin
            rd(RA[i]);
            chk("register", RV[i], d);
        end
    endtask
    task automatic t_led();
        int hi;
        int st;
        led(hi, st);
        chk("led_half", 16'h0190, hi);
        chk("lag", 16'h0065, st);
        hdr(`REG_RATE);
        put(8'h08);
        put(8'h03);
        u_i2c_host.stop();
        led(hi, st);
        chk("led_half", 16'h00C8, hi);
        chk("lag", 16'h0033, st);
        for (int v = 0; v < 2; v++) begin
            wr(`REG_LAG, 8'(v));
            led(hi, st);
            chk("lag", 16'h0001, st);
        end
    endtask
    task automatic t_irq();
        for (int p = 0; p < 2; p++) begin
            wr(`REG_IRQ_SETUP, 8'h02 | 8'(p));
            meas(1'b1);
            wpin(p[0], 8);
            meas(1'b0);
            wpin(!p[0], 8);
        end
        wr(`REG_IRQ_SETUP, 8'h00);
        meas(1'b1);
        meas(1'b0);
        tick(6);
        chk("irq_pin", 16'h0000, irq_pin);
        rd(`REG_IRQ_STATUS);
        chk("status", 16'h0001, d);
        wpin(1'b1, 8);
        wr(`REG_IRQ_SETUP, 8'h06);
        repeat (2) begin
            meas(1'b1);
            wpin(1'b0, 8);
            wpin(1'b1, 8);
        end
        meas(1'b0);
    endtask
    task automatic t_writes();
        logic k;
        wr(`REG_IDENT, 8'h3C);
        rd(`REG_IDENT);
        chk("ident", 16'h00A1, d);
        wr(`REG_RATE, 8'hFF);
        rd(`REG_RATE);
        chk("rate", 16'h001F, d);
        wr(`REG_IRQ_SETUP, 8'hFF);
        rd(`REG_IRQ_SETUP);
        chk("setup", 16'h0007, d);
        u_i2c_host.start();
        u_i2c_host.wbyte(8'h70, k);
        chk("foreign_ack", 16'h0000, k);
        u_i2c_host.stop();
    endtask
    task automatic t_restart();
        int r0;
        meas(1'b1);
        chk("irq_status", 16'h0001, irq_status);
        r0 = restarts;
        wr(`REG_RESTART, 8'h01);
        tick(2);
        chk("restarts", 16'h0001, 16'(restarts - r0));
        chk("irq_status", 16'h0000, irq_status);
        t_defaults();
    endtask
    task automatic finish_test();
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        resetn = 1'b0;
        meas_done = 1'b0;
        out_of_window = 1'b0;
        tick(20);
        resetn = 1'b1;
        t_defaults();
        t_led();
        t_irq();
        t_writes();
        t_restart();
        finish_test();
    end
    // the tests need under a fifth of this span
    initial begin
        tick(100000);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
